// >>> hw/cst_map.svh
// Register offsets, field positions, reset values and the functional summary.
// Assumes inclusion by the prescaler and register design files of the status block.
//
// Function
// [RULE_01] Stack room clears at pointer Fh or on a wrap, else reads 1.
// [RULE_02] Disable bit blocks core_irq, not irq; else only enabled sources may fire.
// [RULE_03] Powerdown flag sets at power-up and on each watchdog clear op.
// [RULE_04] The powerdown flag is cleared when the sleep op executes.
// [RULE_05] A power-on reset clears the power-on flag until software sets it.
// [RULE_06] Timer0 control bit 7 picks the irq pin edge, 1 rising, 0 falling.
// [RULE_07] Source 1 is instr clock; code n<8 divides by 2^n, 1xxx by 256.
// [RULE_08] External source: input edge bit picks rising (1) or falling (0).
// [RULE_09] Any reset sets stack room; after an Fh to 0h wrap it stays clear.
// [RULE_10] Expiry, powerdown and stack room flags ignore software writes.
// [RULE_11] Brownout flag marks a brown-out reset, unreliable if detector off.
`ifndef CST_MAP_SVH
`define CST_MAP_SVH

// ============================================================
// Register offsets
`define CST_OFF_T0CTL    8'h05
`define CST_OFF_STATUS   8'h06
`define CST_OFF_IRQ_STAT 8'h07
`define CST_OFF_IRQ_MASK 8'h08

// ============================================================
// Status register fields
`define CST_B_STACK      5
`define CST_B_GIRQD      4
`define CST_B_WDT        3
`define CST_B_PD         2
`define CST_B_POR        1
`define CST_B_BOR        0

// ============================================================
// Timer0 control fields and reset, stack top and prescaler limit
`define CST_B_EDGE       7
`define CST_B_T0EDGE     6
`define CST_B_T0SRC      5
`define CST_T0CTL_RST    8'h00
`define CST_SP_TOP       4'hf
`define CST_PS_MAX       8'hff

// ============================================================
// Interrupt status bits
`define CST_I_EXT        0
`define CST_I_T0EXT      1
`define CST_I_T0TICK     2
`define CST_I_STACK      3
`define CST_NIRQ         4

`endif

// >>> hw/cst_pkg.sv
// Types shared by the status block.
// Assumes the constants header is on the include path.
`default_nettype none
package cst_pkg;
    typedef logic [7:0] cst_byte_t;
    typedef enum logic [1:0] {CST_RST_POR, CST_RST_BOR, CST_RST_OTHER}
        cst_rst_kind_t;
endpackage : cst_pkg
`default_nettype wire

// >>> hw/cst_prescaler.sv
// Timer0 prescaler: divides the selected tick stream by the coded ratio.
// Assumes tick_in is a one-cycle pulse in the clk domain.
`include "cst_map.svh"
`default_nettype none
module cst_prescaler #(
    parameter int W = 8
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] ps_code,
    input  wire logic       tick_in,
    output logic            tick_out
);
    import cst_pkg::*;
    logic [W-1:0] cnt_q;
    logic [W-1:0] lim;

    // Codes 0 to 7 divide by 2^n, any 1xxx divides by 256.
    always_comb begin
        lim = ps_code[3] ? W'(`CST_PS_MAX) // [RULE_07]
                         : W'((9'h001 << ps_code[2:0]) - 9'h001);
    end

    // Counter wraps at the limit and emits one pulse per ratio.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_q >= lim) begin
                    cnt_q    <= '0;
                    tick_out <= 1'b1; // [RULE_07]
                end else begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end
endmodule : cst_prescaler
`default_nettype wire

// >>> hw/cst_regs.sv
// Core status and timer0 control registers with interrupt status and mask.
// Assumes core events arrive as one-cycle pulses on clk and that the pins
// are asynchronous and pass a three-stage synchroniser here.
//
// Design decision made here: the strobed register port.
`include "cst_map.svh"
`default_nettype none
module cst_regs (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire cst_pkg::cst_rst_kind_t rst_kind,
    input  wire logic            bor_enabled,
    input  wire logic [7:0]      addr,
    input  wire cst_pkg::cst_byte_t wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output var cst_pkg::cst_byte_t rdata,
    input  wire logic            push,
    input  wire logic            pop,
    input  wire logic            wdt_clear_op,
    input  wire logic            sleep_op,
    input  wire logic            wdt_expire,
    input  wire logic            instr_tick,
    input  wire logic            ext_irq_pin,
    input  wire logic            timer0_ext_clock_pin,
    input  wire logic [7:0]      src_enable,
    input  wire logic [7:0]      src_pending,
    output logic                 core_irq,
    output logic                 timer0_tick,
    output logic                 ext_irq_flag,
    output logic                 timer0_ext_edge_flag,
    output logic                 global_irq_disable,
    output logic                 irq
);
    import cst_pkg::*;

    // ============================================================
    // State
    logic [3:0]  sp_q;
    logic        stack_room_q;
    logic        stack_lock_q;
    logic        gid_q;
    logic        wdt_q;
    logic        pd_q;
    logic        por_q;
    logic        bor_q;
    cst_byte_t   t0ctl_q;
    logic [`CST_NIRQ-1:0] ist_q;
    logic [`CST_NIRQ-1:0] imask_q;
    logic [2:0]  eip_q;
    logic [2:0]  tck_q;
    logic        eip_lvl_q;
    logic        tck_lvl_q;
    logic        ps_tick;
    logic        ext_rise;
    logic        ext_fall;
    logic        tck_rise;
    logic        tck_fall;
    logic        ext_evt;
    logic        t0_evt;
    logic        t0_src;
    logic [`CST_NIRQ-1:0] ev;
    cst_byte_t   status_v;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    // ============================================================
    // Pin synchronisers: stage 0 feeds only stage 1.
    always_ff @(posedge clk) begin
        if (rst) begin
            eip_q <= 3'h0;
            tck_q <= 3'h0;
        end else begin
            eip_q <= {eip_q[1:0], ext_irq_pin};
            tck_q <= {tck_q[1:0], timer0_ext_clock_pin};
        end
    end

    // A pin level is accepted once stages 1 and 2 agree. The accepted
    // level starts at 0, the idle level of both pins, so no false edge
    // follows reset; the price is one more cycle of latency.
    always_ff @(posedge clk) begin
        if (rst) begin
            eip_lvl_q <= 1'b0;
            tck_lvl_q <= 1'b0;
        end else begin
            if (eip_q[1] == eip_q[2]) begin
                eip_lvl_q <= eip_q[2];
            end
            if (tck_q[1] == tck_q[2]) begin
                tck_lvl_q <= tck_q[2];
            end
        end
    end

    // An edge is a change of the accepted level, seen for one cycle.
    assign ext_rise = eip_q[1] & eip_q[2] & ~eip_lvl_q;
    assign ext_fall = ~eip_q[1] & ~eip_q[2] & eip_lvl_q;
    assign tck_rise = tck_q[1] & tck_q[2] & ~tck_lvl_q;
    assign tck_fall = ~tck_q[1] & ~tck_q[2] & tck_lvl_q;

    // Edge selection for the irq pin and the timer0 input.
    assign ext_evt = t0ctl_q[`CST_B_EDGE] ? ext_rise : ext_fall; // [RULE_06]
    assign t0_src  = t0ctl_q[`CST_B_T0SRC];
    // With the internal source the input edge bit is ignored.
    assign t0_evt  = t0_src ? 1'b0
                   : t0ctl_q[`CST_B_T0EDGE] ? tck_rise // [RULE_08]
                   : tck_fall;

    // ============================================================
    // Prescaler on the selected timer0 clock.
    cst_prescaler #(.W(8)) u_ps (
        .clk     (clk),
        .rst     (rst),
        .ps_code (t0ctl_q[4:1]),
        .tick_in (t0_src ? instr_tick : t0_evt), // [RULE_07]
        .tick_out(ps_tick)
    );

    // ============================================================
    // Stack pointer and its room flag; the pointer is not visible.
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_q         <= 4'h0;
            stack_room_q <= 1'b1; // [RULE_09]
            stack_lock_q <= 1'b0;
        end else begin
            if (push && !pop) begin
                sp_q <= sp_q + 4'h1;
                if (sp_q == `CST_SP_TOP) begin
                    stack_lock_q <= 1'b1; // [RULE_09]
                end
            end else if (pop && !push) begin
                sp_q <= sp_q - 4'h1;
            end
            // Pointer at Fh clears the flag; a wrap clears it until reset.
            if (stack_lock_q || sp_q == `CST_SP_TOP) begin
                stack_room_q <= 1'b0; // [RULE_01]
            end else begin
                stack_room_q <= 1'b1; // [RULE_01]
            end
        end
    end

    // ============================================================
    // Global disable bit, written by software only.
    always_ff @(posedge clk) begin
        if (rst) begin
            gid_q <= 1'b1;
        end else if (wr && hit(addr, `CST_OFF_STATUS)) begin
            gid_q <= wdata[`CST_B_GIRQD];
        end
    end

    // Watchdog and powerdown flags follow device events only.
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_q <= 1'b1;
            pd_q  <= 1'b1; // [RULE_03]
        end else begin
            if (wdt_clear_op) begin
                wdt_q <= 1'b1;
                pd_q  <= 1'b1; // [RULE_03]
            end else if (sleep_op) begin
                pd_q  <= 1'b0; // [RULE_04]
            end
            if (wdt_expire) begin
                wdt_q <= 1'b0;
            end
        end
    end

    // Power-on flag: of the resets only a power-on reset clears it, so a later external
    // or watchdog reset leaves the earlier cause readable.
    always_ff @(posedge clk) begin
        if (rst) begin
            if (rst_kind == CST_RST_POR) begin
                por_q <= 1'b0; // [RULE_05]
            end
        end else if (wr && hit(addr, `CST_OFF_STATUS)) begin
            por_q <= wdata[`CST_B_POR]; // [RULE_05]
        end
    end

    // Brown-out flag: cleared by a brown-out reset while the detector is
    // on, and by a power-on reset so that it never starts unknown. With
    // the detector off its value carries no meaning.
    always_ff @(posedge clk) begin
        if (rst) begin
            if (rst_kind == CST_RST_POR
                || (rst_kind == CST_RST_BOR && bor_enabled)) begin
                bor_q <= 1'b0; // [RULE_11]
            end
        end else if (wr && hit(addr, `CST_OFF_STATUS)) begin
            bor_q <= wdata[`CST_B_BOR]; // [RULE_11]
        end
    end

    // Software writes never reach the device-owned bits.
    always_comb begin
        status_v = 8'h00;
        status_v[`CST_B_STACK] = stack_room_q; // [RULE_10]
        status_v[`CST_B_GIRQD] = gid_q;
        status_v[`CST_B_WDT]   = wdt_q;
        status_v[`CST_B_PD]    = pd_q;
        status_v[`CST_B_POR]   = por_q;
        status_v[`CST_B_BOR]   = bor_q;
    end

    // ============================================================
    // Timer0 control register; bit 0 is not implemented.
    always_ff @(posedge clk) begin
        if (rst) begin
            t0ctl_q <= `CST_T0CTL_RST;
        end else if (wr && hit(addr, `CST_OFF_T0CTL)) begin
            t0ctl_q <= {wdata[7:1], 1'b0};
        end
    end

    // ============================================================
    // Sticky interrupt status: an event in the clear cycle is kept.
    assign ev[`CST_I_EXT]    = ext_evt;
    assign ev[`CST_I_T0EXT]  = t0_evt;
    assign ev[`CST_I_T0TICK] = ps_tick;
    assign ev[`CST_I_STACK]  = (push & ~pop & sp_q == `CST_SP_TOP);

    genvar gi;
    generate
        for (gi = 0; gi < `CST_NIRQ; gi++) begin : g_ist
            always_ff @(posedge clk) begin
                if (rst) begin
                    ist_q[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    ist_q[gi] <= 1'b1;
                end else if (wr && hit(addr, `CST_OFF_IRQ_STAT)
                             && wdata[gi]) begin
                    ist_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            imask_q <= '0;
        end else if (wr && hit(addr, `CST_OFF_IRQ_MASK)) begin
            imask_q <= wdata[`CST_NIRQ-1:0];
        end
    end

    // ============================================================
    // Registered outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq                  <= 1'b0;
            core_irq             <= 1'b0;
            timer0_tick          <= 1'b0;
            ext_irq_flag         <= 1'b0;
            timer0_ext_edge_flag <= 1'b0;
            global_irq_disable   <= 1'b1;
        end else begin
            irq                  <= |(ist_q & imask_q);
            // Disable wins over every enabled source.
            core_irq             <= ~gid_q
                & |(src_enable & src_pending); // [RULE_02]
            timer0_tick          <= ps_tick;
            ext_irq_flag         <= ext_evt; // [RULE_06]
            timer0_ext_edge_flag <= t0_evt; // [RULE_08]
            global_irq_disable   <= gid_q;
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `CST_OFF_T0CTL:    rdata <= t0ctl_q;
                `CST_OFF_STATUS:   rdata <= status_v;
                `CST_OFF_IRQ_STAT: rdata <= 8'(ist_q);
                `CST_OFF_IRQ_MASK: rdata <= 8'(imask_q);
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ============================================================
    // Checks. Each assertion watches state or outputs that this block drives; the
    // reset cycles are left out because the flags are being loaded then.
    a_gid_blocks: assert property ( // [RULE_02]
        @(posedge clk) disable iff (rst) gid_q |=> !core_irq)
        else $error("irq while disabled");
    a_sleep_pd: assert property ( // [RULE_04]
        @(posedge clk) disable iff (rst) sleep_op && !wdt_clear_op |=> !pd_q)
        else $error("pd not cleared");
    a_clr_pd: assert property ( // [RULE_03]
        @(posedge clk) disable iff (rst) wdt_clear_op |=> pd_q && wdt_q)
        else $error("pd not set");
    a_stack_top: assert property ( // [RULE_01]
        @(posedge clk) disable iff (rst) sp_q == `CST_SP_TOP |=> !stack_room_q)
        else $error("room kept");
    a_room_back: assert property ( // [RULE_01]
        @(posedge clk) disable iff (rst)
        !stack_lock_q && sp_q != `CST_SP_TOP |=> stack_room_q)
        else $error("room not restored");
    a_stack_lock: assert property ( // [RULE_09]
        @(posedge clk) disable iff (rst) stack_lock_q |=> !stack_room_q [*3])
        else $error("lock lost");
    a_wr_ro_bits: assert property ( // [RULE_10]
        @(posedge clk) disable iff (rst)
        wr && hit(addr, `CST_OFF_STATUS) && !wdt_clear_op && !sleep_op
        |=> pd_q == $past(pd_q))
        else $error("pd written");
    a_gid_write: assert property ( // [RULE_02]
        @(posedge clk) disable iff (rst) wr && hit(addr, `CST_OFF_STATUS)
        |=> gid_q == $past(wdata[`CST_B_GIRQD]))
        else $error("disable not written");
    a_edge_rise: assert property ( // [RULE_06]
        @(posedge clk) disable iff (rst)
        ext_rise && t0ctl_q[`CST_B_EDGE] |=> ext_irq_flag)
        else $error("rise missed");
    a_edge_fall: assert property ( // [RULE_06]
        @(posedge clk) disable iff (rst)
        ext_fall && !t0ctl_q[`CST_B_EDGE] |=> ext_irq_flag)
        else $error("fall missed");
    a_int_src: assert property ( // [RULE_08]
        @(posedge clk) disable iff (rst) t0_src |=> !timer0_ext_edge_flag)
        else $error("edge used");
    a_t0ctl_write: assert property ( // [RULE_07]
        @(posedge clk) disable iff (rst) wr && hit(addr, `CST_OFF_T0CTL)
        |=> t0ctl_q == {$past(wdata[7:1]), 1'b0})
        else $error("timer0 control write");
    a_por_write: assert property ( // [RULE_05]
        @(posedge clk) disable iff (rst) wr && hit(addr, `CST_OFF_STATUS)
        |=> por_q == $past(wdata[`CST_B_POR]))
        else $error("por write");
    a_irq_sticky: assert property (
        @(posedge clk) disable iff (rst)
        1'b1 |=> (ist_q & $past(ev)) == $past(ev))
        else $error("event lost");
    a_irq_level: assert property (
        @(posedge clk) disable iff (rst) |(ist_q & imask_q) |=> irq)
        else $error("irq low");
    a_irq_quiet: assert property (
        @(posedge clk) disable iff (rst) !(|(ist_q & imask_q)) |=> !irq)
        else $error("irq high");
    a_rdata_idle: assert property (
        @(posedge clk) disable iff (rst) !rd |=> rdata == 8'h00)
        else $error("read data stands");
    c_sleep: cover property (@(posedge clk) sleep_op);
    c_wrap: cover property (@(posedge clk) stack_lock_q);
    c_tick: cover property (@(posedge clk) ps_tick);
    c_ext_edge: cover property (@(posedge clk) ext_evt);
    c_irq: cover property (@(posedge clk) irq);
endmodule : cst_regs
`default_nettype wire

// >>> testbench/test_core_status_timer0_ctrl_regs.sv
// Self-checking bench for the core status and timer0 control registers.
// Assumes cst_pkg and cst_regs are compiled first; drives every port itself.
`default_nettype none
module test_core_status_timer0_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import cst_pkg::*;

    // ============================================================
    // Signals and model state
    logic          clk, rst, bor_enabled, wr, rd;
    cst_rst_kind_t rst_kind;
    logic [7:0]    addr, src_enable, src_pending, v;
    cst_byte_t     wdata, rdata;
    logic          push, pop, wdt_clear_op, sleep_op, wdt_expire, instr_tick;
    logic          ext_irq_pin, timer0_ext_clock_pin, core_irq, timer0_tick;
    logic          ext_irq_flag, timer0_ext_edge_flag, global_irq_disable, irq;
    logic [15:0]   rnd;
    int            miscompares, checked, n_ext, n_t0e, n_tick, n0, m0;
    int            sp, locked, exp_st, e, c;

    cst_regs cst_regs_i (
        .clk(clk), .rst(rst), .rst_kind(rst_kind), .bor_enabled(bor_enabled),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .push(push), .pop(pop), .wdt_clear_op(wdt_clear_op),
        .sleep_op(sleep_op), .wdt_expire(wdt_expire), .instr_tick(instr_tick),
        .ext_irq_pin(ext_irq_pin),
        .timer0_ext_clock_pin(timer0_ext_clock_pin),
        .src_enable(src_enable), .src_pending(src_pending),
        .core_irq(core_irq), .timer0_tick(timer0_tick),
        .ext_irq_flag(ext_irq_flag),
        .timer0_ext_edge_flag(timer0_ext_edge_flag),
        .global_irq_disable(global_irq_disable), .irq(irq));

    // The clock runs at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts one-cycle pulses so short flags are never missed by a poll.
    always @(posedge clk) begin
        if (ext_irq_flag === 1'b1)
            n_ext++;
        if (timer0_ext_edge_flag === 1'b1)
            n_t0e++;
        if (timer0_tick === 1'b1)
            n_tick++;
    end

    // ============================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Stack room reads clear at the top slot and stays clear after a wrap.
    function automatic logic [7:0] exp_status();
        return 8'((locked != 0 || sp == 15) ? 0 : 32) | 8'(exp_st);
    endfunction : exp_status

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(16'(rdata), 16'(exp));
    endtask : chk_rd

    task automatic do_reset(input cst_rst_kind_t k);
        rst_kind <= k;
        rst      <= 1'b1;
        repeat (3) @(posedge clk);
        rst    <= 1'b0;
        sp     = 0;
        locked = 0;
        // Power-on clears both cause flags, brown-out only its own.
        exp_st = 'h1c | (k == CST_RST_POR ? 0
                         : exp_st & (k == CST_RST_BOR ? 'h02 : 'h03));
        @(posedge clk);
    endtask : do_reset

    // Core events: 0 push, 1 pop, 2 watchdog clear, 3 sleep, 4 expiry.
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: push <= 1'b1;
            1: pop <= 1'b1;
            2: wdt_clear_op <= 1'b1;
            3: sleep_op <= 1'b1;
            default: wdt_expire <= 1'b1;
        endcase
        @(posedge clk);
        {push, pop, wdt_clear_op, sleep_op, wdt_expire} <= 5'h00;
        if (k == 0 && sp == 15)
            locked = 1;
        if (k == 0)
            sp = (sp + 1) % 16;
        if (k == 1)
            sp = (sp + 15) % 16;
        if (k == 2)
            exp_st = exp_st | 'h0c;
        if (k == 3)
            exp_st = exp_st & 'h1b;
        if (k == 4)
            exp_st = exp_st & 'h17;
        @(posedge clk);
    endtask : ev

    // Drives both pins to one level and counts flags over the sync delay.
    task automatic pins(input logic lvl, input int exp);
        n0 = n_ext;
        m0 = n_t0e;
        @(posedge clk);
        ext_irq_pin          <= lvl;
        timer0_ext_clock_pin <= lvl;
        repeat (8) @(posedge clk);
        check(16'(n_ext - n0), 16'(exp));
        check(16'(n_t0e - m0), 16'(exp));
    endtask : pins

    // A hang counts as a mismatch and goes to the closing report.
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    // ============================================================
    // Main sequence
    initial begin
        {rst, bor_enabled, wr, rd, push, pop} = 6'h30;
        {wdt_clear_op, sleep_op, wdt_expire, instr_tick} = 4'h0;
        {ext_irq_pin, timer0_ext_clock_pin} = 2'h0;
        rst_kind    = CST_RST_POR;
        addr        = 8'h00;
        wdata       = 8'h00;
        src_enable  = 8'h00;
        src_pending = 8'h00;
        rnd         = 16'hc9ca;
        do_reset(CST_RST_POR);
        chk_rd(8'h05, 8'h00);
        chk_rd(8'h06, exp_status());
        chk_rd(8'h40, 8'h00);
        // Flags owned by the core logic must survive software writes.
        wr_reg(8'h06, 8'hff);
        exp_st = 'h1f;
        chk_rd(8'h06, exp_status());
        wr_reg(8'h06, 8'h00);
        exp_st = 'h0c;
        chk_rd(8'h06, exp_status());
        // Random sources against the global disable.
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            @(posedge clk);
            src_enable  <= rnd[7:0];
            src_pending <= rnd[15:8];
            wr_reg(8'h06, {3'h0, rnd[3], 4'h0});
            exp_st = 'h0c | (rnd[3] ? 'h10 : 0);
            v = 8'(!rnd[3] && |(rnd[7:0] & rnd[15:8]));
            repeat (3) @(posedge clk);
            #1 check(16'(core_irq), 16'(v));
            check(16'(global_irq_disable), 16'(rnd[3]));
        end
        for (int k = 3; k >= 2; k--) begin
            ev(k);
            chk_rd(8'h06, exp_status());
        end
        ev(4);
        chk_rd(8'h06, exp_status());
        ev(2);
        chk_rd(8'h06, exp_status());
        // Fill to the top, step back, then wrap and check the lock.
        for (int i = 0; i < 20; i++) begin
            ev((i == 15 || i == 19) ? 1 : 0);
            chk_rd(8'h06, exp_status());
        end
        check(16'(irq), 16'h0000);
        wr_reg(8'h08, 8'h08);
        repeat (2) @(posedge clk);
        #1 check(16'(irq), 16'h0001);
        wr_reg(8'h07, 8'h08);
        repeat (2) @(posedge clk);
        #1 check(16'(irq), 16'h0000);
        wr_reg(8'h08, 8'h00);
        // Set both cause flags so the brown-out reset shows which it clears.
        wr_reg(8'h06, 8'h03);
        exp_st = 'h0f;
        chk_rd(8'h06, exp_status());
        do_reset(CST_RST_BOR);
        chk_rd(8'h06, exp_status());
        // Bit 0 of timer0 control is unimplemented and reads as zero.
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            wr_reg(8'h05, rnd[7:0]);
            chk_rd(8'h05, rnd[7:0] & 8'hfe);
        end
        for (e = 0; e < 2; e++) begin
            wr_reg(8'h05, e ? 8'hc0 : 8'h00);
            pins(1'b1, e);
            pins(1'b0, 1 - e);
        end
        // Each ratio from a fresh reset so the divider phase is known.
        for (c = 0; c < 10; c++) begin
            do_reset(CST_RST_OTHER);
            wr_reg(8'h05, 8'h20 | 8'((c == 9 ? 15 : c) << 1));
            n0 = n_tick;
            repeat (256) begin
                @(posedge clk);
                instr_tick <= 1'b1;
                @(posedge clk);
                instr_tick <= 1'b0;
            end
            repeat (4) @(posedge clk);
            check(16'(n_tick - n0), 16'(c > 7 ? 1 : 256 >> c));
        end
        report_and_stop();
    end
endmodule : test_core_status_timer0_ctrl_regs
`default_nettype wire
